// [src/txp_consts.vh]
// Constants for the transmit nibble port and interpolation front end.
`ifndef TXP_CONSTS_VH
`define TXP_CONSTS_VH

// Register word indices; byte address is four times the index.
`define TXP_IDX_CTRL 6'h00
`define TXP_IDX_GAIN 6'h06
`define TXP_IDX_MODE 6'h07
`define TXP_IDX_STAT 6'h08

// Control register fields.
`define TXP_CTRL_TX_EN 0
`define TXP_CTRL_CAP_FALL 1
`define TXP_CTRL_CLK_INV 2
`define TXP_CTRL_CLK_DIS 3
`define TXP_CTRL_NIB_SWAP 4
`define TXP_CTRL_MUX_EN 5
`define TXP_CTRL_OFS_BIN 6
`define TXP_CTRL_PASS 7
`define TXP_CTRL_L_LO 8
`define TXP_CTRL_L_HI 9
`define TXP_CTRL_SRST 31
`define TXP_CTRL_RESET 32'h0000_0020

// Filter mode field and codes.
`define TXP_MODE_LO 4
`define TXP_MODE_HI 7
`define TXP_MODE_RESET 32'h0000_0000
`define TXP_M_LP4 4'h0
`define TXP_M_LP2 4'h1
`define TXP_M_ADJ4 4'h4
`define TXP_M_ADJ2 4'h5
`define TXP_M_LOW4 4'h8
`define TXP_M_UPP4 4'hc

// Impulse peak latency and flush length in DAC clock cycles.
`define TXP_LAT_4X 8'h56
`define TXP_LAT_LP2 8'h1e
`define TXP_LAT_ADJ2 8'h03
`define TXP_LAT_PASS 8'h02
`define TXP_FL_4X 8'h80
`define TXP_FL_2X 8'h30
`define TXP_FL_LOW 8'h94
`define TXP_FL_UPP 8'h8e
`define TXP_FL_PASS 8'h01

// Status fields.
`define TXP_ST_SETTLED 8
`define TXP_ST_OVF 9
`define TXP_ST_UNF 10
`define TXP_ST_GAIN_PIN 11

// Timing: DAC tick falls on this count of a four-state divider; pin sync latency.
`define TXP_DAC_DIV 2'h3
`define TXP_SYNC_LAT 3

// Bus responses.
`define TXP_RESP_OK 2'h0
`define TXP_RESP_ERR 2'h2

`endif

// [src/txp_fifo.v]
// Synchronous word FIFO with valid/ready on both sides.
module txp_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire clear,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill level
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ff;
  reg [AW:0] rd_ff;
  wire push;
  wire pop;

  assign level = wr_ff - rd_ff;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data = mem[rd_ff[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge aclk) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule

// [src/txp_top.v]
// Transmit nibble port, sample FIFO, interpolation filter and register slave.
`include "txp_consts.vh"
module txp_top #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter DL_AW = 7
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire awvalid,
  output reg awready_ff,
  input wire [7:0] awaddr,
  input wire wvalid,
  output reg wready_ff,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid_ff,
  input wire bready,
  output reg [1:0] bresp_ff,
  // AXI4-Lite read
  input wire arvalid,
  output reg arready_ff,
  input wire [7:0] araddr,
  output reg rvalid_ff,
  input wire rready,
  output reg [31:0] rdata_ff,
  output reg [1:0] rresp_ff,
  // Transmit nibble port pins
  input wire [5:0] tx_nibble,
  input wire tx_strobe,
  input wire gain_access_sel,
  output reg tx_port_clk_ff,
  // Converter side
  output reg [11:0] dac_data_ff,
  output reg dac_strobe_ff,
  output reg ref_osc_tick_ff,
  output reg [5:0] rx_gain_ff
);
  reg [31:0] ctrl_ff;
  reg [31:0] mode_ff;
  reg ovf_ff;
  reg unf_ff;
  reg srst_ff;
  wire port_rst = !aresetn || srst_ff;
  wire [3:0] mode = mode_ff[`TXP_MODE_HI:`TXP_MODE_LO];

  // Pin synchronisers: gain select, strobe, nibble.
  reg [7:0] s1_ff;
  reg [7:0] s2_ff;
  reg [7:0] s3_ff;
  reg [7:0] agr_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
      agr_ff <= 8'h00;
    end else begin
      s1_ff <= {gain_access_sel, tx_strobe, tx_nibble};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      agr_ff <= (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & agr_ff);
    end
  end
  wire [5:0] nib = agr_ff[5:0];
  wire strobe_in = agr_ff[6];
  wire gain_mode = agr_ff[7];

  // Mode decode: interpolation factor, shift, delay and flush figures.
  reg [2:0] k_fac;
  reg [1:0] k_sh;
  reg [7:0] lat;
  reg [7:0] flush_len;
  reg [1:0] mod_sel;
  always @* begin
    k_fac = 3'h4;
    k_sh = 2'h2;
    lat = `TXP_LAT_4X;
    flush_len = `TXP_FL_4X;
    mod_sel = 2'h0;
    case (mode)
      `TXP_M_LP4: begin
        mod_sel = 2'h0;
      end
      `TXP_M_LP2: begin
        k_fac = 3'h2;
        k_sh = 2'h1;
        lat = `TXP_LAT_LP2;
        flush_len = `TXP_FL_2X;
      end
      `TXP_M_ADJ4: begin
        mod_sel = 2'h1;
      end
      `TXP_M_ADJ2: begin
        k_fac = 3'h2;
        k_sh = 2'h1;
        lat = `TXP_LAT_ADJ2;
        flush_len = `TXP_FL_2X;
        mod_sel = 2'h1;
      end
      `TXP_M_LOW4: begin
        flush_len = `TXP_FL_LOW;
        mod_sel = 2'h2;
      end
      `TXP_M_UPP4: begin
        flush_len = `TXP_FL_UPP;
        mod_sel = 2'h3;
      end
      default: begin
        k_fac = 3'h1;
        k_sh = 2'h0;
        lat = `TXP_LAT_PASS;
        flush_len = `TXP_FL_PASS;
      end
    endcase
    // Unlisted codes and the pass bit both bypass filtering.
    if (ctrl_ff[`TXP_CTRL_PASS]) begin
      k_fac = 3'h1;
      k_sh = 2'h0;
      lat = `TXP_LAT_PASS;
      flush_len = `TXP_FL_PASS;
      mod_sel = 2'h0;
    end
  end

  // Port clock from a divider: half period K cycles with mux, 2K without.
  reg [3:0] hcnt_ff;
  reg pclk_ff;
  wire mux_en = ctrl_ff[`TXP_CTRL_MUX_EN];
  wire [3:0] half_len = mux_en ? {1'b0, k_fac} : {k_fac, 1'b0};
  wire pwrap = (hcnt_ff == half_len - 4'h1) || (hcnt_ff >= half_len);
  wire nxt_pclk = pwrap ? !pclk_ff : pclk_ff;
  wire rise = pwrap && !pclk_ff;
  wire fall = pwrap && pclk_ff;
  wire cap_evt = ctrl_ff[`TXP_CTRL_CAP_FALL] ? fall : rise;
  reg [`TXP_SYNC_LAT-1:0] evt_ff;
  always @(posedge aclk) begin
    if (port_rst) begin
      hcnt_ff <= 4'h0;
      pclk_ff <= 1'b0;
      tx_port_clk_ff <= 1'b0;
      evt_ff <= {`TXP_SYNC_LAT{1'b0}};
    end else begin
      hcnt_ff <= pwrap ? 4'h0 : hcnt_ff + 4'h1;
      pclk_ff <= nxt_pclk;
      tx_port_clk_ff <= !ctrl_ff[`TXP_CTRL_CLK_DIS] && (nxt_pclk ^ ctrl_ff[`TXP_CTRL_CLK_INV]);
      // The pins reach agr_ff four cycles late; the capture event is held back three cycles.
      evt_ff <= {evt_ff[`TXP_SYNC_LAT-2:0], cap_evt};
    end
  end
  wire capture = evt_ff[`TXP_SYNC_LAT-1];

  // Nibble assembly into words, or direct gain writes.
  reg [5:0] first_ff;
  reg have_ff;
  reg push_ff;
  reg [11:0] push_data_ff;
  wire fifo_in_ready;
  wire [11:0] pair = ctrl_ff[`TXP_CTRL_NIB_SWAP] ? {nib, first_ff} : {first_ff, nib};
  always @(posedge aclk) begin
    if (port_rst) begin
      first_ff <= 6'h00;
      have_ff <= 1'b0;
      push_ff <= 1'b0;
      push_data_ff <= 12'h000;
    end else begin
      push_ff <= 1'b0;
      if (capture) begin
        if (gain_mode) begin
          have_ff <= 1'b0;
        end else if (!mux_en) begin
          push_ff <= 1'b1;
          push_data_ff <= {nib, 6'h00};
        end else if (strobe_in) begin
          first_ff <= nib;
          have_ff <= 1'b1;
        end else if (have_ff) begin
          push_ff <= 1'b1;
          push_data_ff <= pair;
          have_ff <= 1'b0;
        end
      end
    end
  end

  // DAC clock ticks and reference tick every L DAC cycles.
  reg [1:0] dcnt_ff;
  reg [3:0] rcnt_ff;
  wire tick = (dcnt_ff == `TXP_DAC_DIV);
  wire [1:0] lcode = ctrl_ff[`TXP_CTRL_L_HI:`TXP_CTRL_L_LO];
  wire [3:0] l_fac = 4'h1 << lcode;
  always @(posedge aclk) begin
    if (!aresetn) begin
      dcnt_ff <= 2'h0;
      rcnt_ff <= 4'h0;
      ref_osc_tick_ff <= 1'b0;
      dac_strobe_ff <= 1'b0;
    end else begin
      dcnt_ff <= dcnt_ff + 2'h1;
      dac_strobe_ff <= tick;
      ref_osc_tick_ff <= 1'b0;
      if (tick) begin
        if (rcnt_ff >= l_fac - 4'h1) begin
          rcnt_ff <= 4'h0;
          ref_osc_tick_ff <= 1'b1;
        end else begin
          rcnt_ff <= rcnt_ff + 4'h1;
        end
      end
    end
  end

  // Sample FIFO between the port and the filter.
  wire fifo_out_valid;
  wire [11:0] fifo_out_data;
  wire [FIFO_AW:0] fifo_level;
  reg [1:0] ph_ff;
  wire load = tick && (ph_ff == 2'h0);
  wire fifo_pop = load && ctrl_ff[`TXP_CTRL_TX_EN];
  txp_fifo #(
    .WIDTH(12),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(srst_ff),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .in_data(push_data_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Interpolator history and delay line are never reset, so they survive
  // both resets; the zeros loaded whenever no word is popped clear them.
  reg [11:0] cur_ff;
  reg [11:0] prv_ff;
  reg [11:0] dl [0:(1<<DL_AW)-1];
  reg [DL_AW-1:0] wp_ff;
  reg [1:0] mc_ff;
  reg [7:0] fl_ff;
  wire [11:0] x_in = (fifo_pop && fifo_out_valid) ? fifo_out_data : 12'h000;
  wire [2:0] weight = (ph_ff == 2'h0) ? k_fac : {1'b0, ph_ff};
  wire signed [12:0] diff = $signed({cur_ff[11], cur_ff}) - $signed({prv_ff[11], prv_ff});
  wire signed [16:0] prod = diff * $signed({1'b0, weight});
  wire signed [16:0] step = prod >>> k_sh;
  wire [11:0] y = prv_ff + step[11:0];
  wire [11:0] y_neg = (y == 12'h800) ? 12'h7ff : (12'h000 - y);
  reg [11:0] y_mod;
  always @* begin
    case (mod_sel)
      2'h1: y_mod = mc_ff[0] ? y_neg : y;
      2'h2: y_mod = mc_ff[0] ? 12'h000 : (mc_ff[1] ? y_neg : y);
      2'h3: y_mod = !mc_ff[0] ? 12'h000 : (mc_ff[1] ? y_neg : y);
      default: y_mod = y;
    endcase
  end
  // Peak leaves the interpolator K ticks after the pop; delay makes up the rest.
  wire [7:0] dly = lat - {5'h00, k_fac};
  wire [DL_AW-1:0] rp = wp_ff - dly[DL_AW-1:0];
  always @(posedge aclk) begin
    if (tick) begin
      if (load) begin
        prv_ff <= cur_ff;
        cur_ff <= x_in;
      end
      dl[wp_ff] <= y_mod;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ph_ff <= 2'h0;
      mc_ff <= 2'h0;
      wp_ff <= {DL_AW{1'b0}};
      fl_ff <= 8'h00;
      dac_data_ff <= 12'h000;
    end else if (tick) begin
      ph_ff <= (ph_ff >= k_fac[1:0] - 2'h1 || k_fac[2]) && ph_ff == (k_fac - 3'h1) ?
               2'h0 : ph_ff + 2'h1;
      mc_ff <= mc_ff + 2'h1;
      wp_ff <= wp_ff + 1'b1;
      if (load && x_in != 12'h000) begin
        fl_ff <= 8'h00;
      end else if (fl_ff != 8'hff) begin
        fl_ff <= fl_ff + 8'h01;
      end
      // offset binary is the two's complement word with its top bit flipped.
      dac_data_ff <= dl[rp] ^ {ctrl_ff[`TXP_CTRL_OFS_BIN], 11'h000};
    end
  end
  wire settled = (fl_ff >= flush_len);

  // Register slave: write takes address and data together.
  wire aw_hs = awready_ff && awvalid && wvalid;
  wire [5:0] widx = awaddr[7:2];
  wire [5:0] ridx = araddr[7:2];
  wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire wr_ctrl = aw_hs && widx == `TXP_IDX_CTRL;
  wire wr_mode = aw_hs && widx == `TXP_IDX_MODE;
  wire wr_gain = aw_hs && widx == `TXP_IDX_GAIN;
  wire wr_stat = aw_hs && widx == `TXP_IDX_STAT;
  wire w_ok = wr_ctrl || wr_mode || wr_gain || wr_stat;
  wire ovf_evt = push_ff && !fifo_in_ready;
  wire unf_evt = fifo_pop && !fifo_out_valid;
  wire [31:0] stat = {20'h00000, gain_mode, unf_ff, ovf_ff, settled,
                      {(7-FIFO_AW){1'b0}}, fifo_level};
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TXP_RESP_OK;
      ctrl_ff <= `TXP_CTRL_RESET;
      mode_ff <= `TXP_MODE_RESET;
      rx_gain_ff <= 6'h00;
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
      srst_ff <= 1'b0;
    end else begin
      awready_ff <= !awready_ff && !bvalid_ff && awvalid && wvalid;
      wready_ff <= !awready_ff && !bvalid_ff && awvalid && wvalid;
      srst_ff <= 1'b0;
      if (aw_hs) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= w_ok ? `TXP_RESP_OK : `TXP_RESP_ERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_ff <= (ctrl_ff & ~wmask) | (wdata & wmask & ~(32'h1 << `TXP_CTRL_SRST));
        srst_ff <= wdata[`TXP_CTRL_SRST] && wstrb[3];
      end
      if (wr_mode) begin
        mode_ff <= (mode_ff & ~wmask) | (wdata & wmask & 32'h0000_00f0);
      end
      // Pin access wins over a software write in the same cycle.
      if (capture && gain_mode) begin
        rx_gain_ff <= nib;
      end else if (wr_gain && wstrb[0]) begin
        rx_gain_ff <= wdata[5:0];
      end
      // Sticky flags: a new event wins over a write-one clear.
      ovf_ff <= ovf_evt || (ovf_ff && !(wr_stat && wstrb[1] && wdata[`TXP_ST_OVF]));
      unf_ff <= unf_evt || (unf_ff && !(wr_stat && wstrb[1] && wdata[`TXP_ST_UNF]));
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `TXP_RESP_OK;
    end else begin
      arready_ff <= !arready_ff && !rvalid_ff && arvalid;
      if (arready_ff && arvalid) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= `TXP_RESP_OK;
        case (ridx)
          `TXP_IDX_CTRL: rdata_ff <= ctrl_ff;
          `TXP_IDX_MODE: rdata_ff <= mode_ff;
          `TXP_IDX_GAIN: rdata_ff <= {26'h0, rx_gain_ff};
          `TXP_IDX_STAT: rdata_ff <= stat;
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `TXP_RESP_ERR;
          end
        endcase
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule

// [tb/txp_chk_chk.sv]
// Concurrent checks on the register bus handshakes and the DAC tick of txp_top.
module txp_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire awvalid,
  input wire awready_ff,
  input wire wvalid,
  input wire wready_ff,
  input wire bvalid_ff,
  input wire bready,
  input wire [1:0] bresp_ff,
  input wire arvalid,
  input wire arready_ff,
  input wire rvalid_ff,
  input wire rready,
  input wire [31:0] rdata_ff,
  // Converter side
  input wire dac_strobe_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_tick_gap;
    !dac_strobe_ff [*3] ##1 dac_strobe_ff;
  endsequence
  chk_aw_pair: assert property (awready_ff |-> wready_ff && awvalid && wvalid)
    else $error("write taken without both address and data");
  chk_aw_refuse: assert property (bvalid_ff |-> !awready_ff)
    else $error("write taken while a response stands");
  chk_b_follow: assert property (awready_ff |=> bvalid_ff)
    else $error("write response late");
  chk_b_hold: assert property (bvalid_ff && !bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped early");
  chk_ar_pulse: assert property (arready_ff |-> arvalid ##1 !arready_ff)
    else $error("read address ready misbehaves");
  chk_r_follow: assert property (arready_ff |=> rvalid_ff)
    else $error("read data late");
  chk_r_hold: assert property (rvalid_ff && !rready |=> rvalid_ff && $stable(rdata_ff))
    else $error("read data dropped early");
  chk_dac_tick: assert property (dac_strobe_ff |=> s_tick_gap)
    else $error("DAC tick spacing wrong");
endmodule
bind txp_top txp_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready_ff(awready_ff),
  .wvalid(wvalid), .wready_ff(wready_ff), .bvalid_ff(bvalid_ff), .bready(bready),
  .bresp_ff(bresp_ff), .arvalid(arvalid), .arready_ff(arready_ff), .rvalid_ff(rvalid_ff),
  .rready(rready), .rdata_ff(rdata_ff), .dac_strobe_ff(dac_strobe_ff)
);

// [tb/txp_host.sv]
// Host model that sends one word at a time onto the transmit nibble port.
module txp_host (
  // Clock and port pins
  input logic aclk,
  input logic port_clk,
  input logic cap_fall,
  output logic [5:0] tx_nibble,
  output logic tx_strobe,
  // Word request from the bench
  input logic send,
  input logic [11:0] word,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_q;
  logic [1:0] ph;
  logic [11:0] hold;
  // Launching on the edge opposite capture keeps a nibble stable across the capture edge.
  wire launch = (clk_q != port_clk) && (port_clk == cap_fall);
  initial begin
    {clk_q, ph, hold, tx_strobe, busy} = '0;
    tx_nibble = 6'h2a;
  end
  always @(posedge aclk) begin
    clk_q <= port_clk;
    if (send) begin
      hold <= word;
      busy <= 1'h1;
    end
    if (launch) begin
      // Idle nibbles flip every period so a stale value never looks like data.
      tx_nibble <= ~tx_nibble;
      tx_strobe <= 1'h0;
      if (busy && ph == 2'h0) begin
        tx_nibble <= hold[11:6];
        tx_strobe <= 1'h1;
      end
      if (ph == 2'h1) tx_nibble <= hold[5:0];
      if (busy) ph <= ph + 2'h1;
      if (ph == 2'h2) begin
        busy <= 1'h0;
        ph <= 2'h0;
      end
    end
  end
endmodule

// [tb/txp_top_tb_top.sv]
// Testbench for txp_top: registers, nibble port, sample FIFO and DAC output.
`include "txp_consts.vh"
module txp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] ctl = `TXP_IDX_CTRL;
  localparam logic [5:0] mde = `TXP_IDX_MODE;
  localparam logic [5:0] sta = `TXP_IDX_STAT;
  logic aclk = 1'h0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, gain_access_sel, cap_fall, send;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata_ff;
  logic [3:0] wstrb;
  logic [11:0] word, dac_data_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, tx_strobe, tx_port_clk_ff;
  logic dac_strobe_ff, ref_osc_tick_ff, busy;
  logic [1:0] bresp_ff, rresp_ff;
  logic [5:0] tx_nibble, rx_gain_ff;
  logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'hc};
  int n_fail = 0;
  int samples_checked = 0;
  int i;
  txp_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready_ff(awready_ff),
    .awaddr(awaddr), .wvalid(wvalid), .wready_ff(wready_ff), .wdata(wdata), .wstrb(wstrb),
    .bvalid_ff(bvalid_ff), .bready(bready), .bresp_ff(bresp_ff), .arvalid(arvalid),
    .arready_ff(arready_ff), .araddr(araddr), .rvalid_ff(rvalid_ff), .rready(rready),
    .rdata_ff(rdata_ff), .rresp_ff(rresp_ff), .tx_nibble(tx_nibble), .tx_strobe(tx_strobe),
    .gain_access_sel(gain_access_sel), .tx_port_clk_ff(tx_port_clk_ff),
    .dac_data_ff(dac_data_ff), .dac_strobe_ff(dac_strobe_ff),
    .ref_osc_tick_ff(ref_osc_tick_ff), .rx_gain_ff(rx_gain_ff)
  );
  txp_host i_host (
    .aclk(aclk), .port_clk(tx_port_clk_ff), .cap_fall(cap_fall), .tx_nibble(tx_nibble),
    .tx_strobe(tx_strobe), .send(send), .word(word), .busy(busy)
  );
  always #5 aclk = ~aclk;
  task give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tmo(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task wr(input logic [5:0] x, input logic [31:0] d, input logic [3:0] s = 4'hf,
          input logic [1:0] e = 2'h0);
    int n;
    @(posedge aclk);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    awaddr <= {x, 2'h0};
    wdata <= d;
    wstrb <= s;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready_ff) awvalid <= 1'h0;
      if (wready_ff) wvalid <= 1'h0;
      if (bvalid_ff) break;
    end
    bready <= 1'h0;
    tmo(n, 50);
    chk("bresp", bresp_ff, e);
  endtask
  task rd(input logic [5:0] x, input logic [31:0] m, input logic [31:0] ex,
          input logic [1:0] e = 2'h0);
    int n;
    @(posedge aclk);
    arvalid <= 1'h1;
    rready <= 1'h1;
    araddr <= {x, 2'h0};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready_ff) arvalid <= 1'h0;
      if (rvalid_ff) break;
    end
    rready <= 1'h0;
    tmo(n, 50);
    chk("rdata", rdata_ff & m, ex);
    chk("rresp", rresp_ff, e);
  endtask
  task put(input logic [11:0] w);
    int n;
    @(posedge aclk);
    send <= 1'h1;
    word <= w;
    @(posedge aclk);
    send <= 1'h0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (busy && n < 200);
    tmo(n, 200);
  endtask
  // Half period of the port clock (w = 0) or spacing of reference ticks (w = 1).
  task meas(input logic w, input int e);
    int n;
    int k;
    logic p;
    for (k = 0; k < 3; k++) begin
      n = 0;
      p = tx_port_clk_ff;
      do begin
        @(posedge aclk);
        n++;
      end while (n < 40 && !(w ? ref_osc_tick_ff : tx_port_clk_ff !== p));
    end
    chk(w ? "ref_tick" : "port_clk", n, e);
  endtask
  // Loads one word with the filter stalled, then lets it out in pass-through.
  task pt(input logic [31:0] c, input logic [11:0] w, input logic [11:0] e);
    int n;
    wr(ctl, c);
    put(w);
    wr(ctl, c | 32'h81);
    for (n = 0; n < 400 && dac_data_ff !== e; n++) @(posedge aclk);
    chk("dac_data", dac_data_ff, e);
    wr(ctl, c);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
    {wdata, wstrb, gain_access_sel, cap_fall, send, word} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ctl, 32'hffffffff, `TXP_CTRL_RESET);
    rd(mde, 32'hffffffff, `TXP_MODE_RESET);
    rd(6'h3f, 32'hffffffff, 32'h0, `TXP_RESP_ERR);
    wr(6'h3f, 32'h1, 4'hf, `TXP_RESP_ERR);
    for (i = 0; i < 6; i++) begin
      wr(mde, {24'h0, codes[i], 4'h0});
      rd(mde, 32'hff, {24'h0, codes[i], 4'h0});
    end
    wr(mde, 32'h0);
    meas(1'h0, 4);
    wr(mde, 32'h10);
    meas(1'h0, 2);
    wr(mde, 32'h0);
    wr(ctl, 32'h0);
    meas(1'h0, 8);
    wr(ctl, 32'h28);
    meas(1'h0, 40);
    for (i = 0; i < 4; i++) begin
      wr(ctl, 32'h20 | (i << 8));
      meas(1'h1, 4 << i);
    end
    wr(ctl, 32'h21);
    // Zeros popped from the empty buffer fill the filter history before real data.
    repeat (600) @(posedge aclk);
    wr(ctl, 32'h20);
    rd(sta, 32'h500, 32'h500);
    wr(sta, 32'h400, 4'h2);
    rd(sta, 32'h400, 32'h0);
    // The filter stalls while the host overruns the buffer by one word.
    for (i = 0; i < 33; i++) put(12'h100 + i[11:0]);
    rd(sta, 32'h23f, 32'h220);
    wr(ctl, 32'h21);
    // Thirty-two words leave at one per four DAC ticks, so allow 512 cycles and margin.
    repeat (600) @(posedge aclk);
    rd(sta, 32'h3f, 32'h0);
    pt(32'h20, 12'h801, 12'h801);
    pt(32'h30, 12'h801, 12'h060);
    pt(32'h60, 12'h7ff, 12'hfff);
    cap_fall <= 1'h1;
    pt(32'h22, 12'h555, 12'h555);
    gain_access_sel <= 1'h1;
    repeat (8) @(posedge aclk);
    rd(sta, 32'h800, 32'h800);
    put(12'h3cf);
    // Idle nibbles keep writing the gain register, so look before the next capture.
    chk("rx_gain", rx_gain_ff, 6'h0f);
    gain_access_sel <= 1'h0;
    rd(`TXP_IDX_GAIN, 32'h3f, 32'h0f);
    // Soft reset empties the buffer and its control bit reads back as zero.
    put(12'h123);
    rd(sta, 32'h3f, 32'h1);
    wr(ctl, 32'h8000_0022);
    rd(sta, 32'h3f, 32'h0);
    rd(ctl, 32'hffffffff, 32'h22);
    give_verdict();
  end
endmodule
